// *** vah_top.sv ***
// Contract
// RULE1 - run reaching 3 loads hold counter with 5 and clamps run at 3
// RULE2 - run counter increments on raw decision, clears to zero otherwise
// RULE3 - held flag is raw OR hold>=0; then hold decrements if >=0
// RULE4 - reset sets run counter 0 and hold counter -1
// RULE5 - periodic flag updates once per frame on vowel-like lag pattern
// RULE6 - periodic flag blocks threshold and noise model adaptation
// RULE7 - encoder supplies four lag values per frame, one per subframe
// RULE8 - remainder starts at larger lag, minus pair minima of first three
// RULE9 - tally counts pair when min(rem, small-rem) below 2
// RULE10 - tallies shift each frame; periodic when sum reaches 7
// RULE11 - last lag kept as lag zero of next frame; resets to 21
// RULE12 - reset sets periodic flag 1 and both tallies 0
// RULE13 - periodic flag computed after decision, when lags arrive
// RULE14 - decision uses periodic flag of the preceding frame
// RULE15 - decision starts once frame energies and coefficients valid
// RULE16 - reset returns all detector state to initial values
// RULE17 - energies and threshold held as 16-bit exponent plus mantissa
// RULE18 - mantissa normalised to at least 16384, value 2^e*m/32768
// RULE19 - pseudo-float compare decided first by exponents
// RULE20 - floor, margin and lower limit encoded as fixed exp/mant
// RULE21 - pseudo-float work uses only 16- or 32-bit integer ops
// RULE22 - raw decision true when filtered energy exceeds threshold
// RULE23 - equal exponents: compare decided by mantissas
// RULE24 - encoder pulses frame strobe, then separate lags strobe
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module vah_top #(
    parameter int unsigned FRAME_CYCLES = vah_pkg::FRAME_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_valid,
    input  wire vah_pkg::vah_pf_t  filt_energy,
    input  wire vah_pkg::vah_pf_t  thresh,
    input  wire vah_pkg::vah_pf_t  input_frame_energy,
    input  wire logic              lags_valid,
    input  wire vah_pkg::vah_lags_t lags,
    output logic                   vad_flag,
    output logic                   raw_flag,
    output logic                   decision_valid,
    output logic                   periodic,
    output logic                   adapt_allow,
    output logic                   energy_below_floor,
    output logic                   thresh_below_limit
);

    // pseudo-float greater-than, 16-bit compares only
    function automatic logic pf_gt(input vah_pkg::vah_pf_t a, // see RULE17
                                   input vah_pkg::vah_pf_t b);
        if (a.exp != b.exp) begin
            pf_gt = a.exp > b.exp; // see RULE19, RULE21
        end else begin
            pf_gt = a.mant > b.mant; // see RULE23
        end
    endfunction : pf_gt
    function automatic logic signed [16:0] lmin(input logic [15:0] a,
                                                input logic [15:0] b);
        lmin = (a < b) ? {1'b0, a} : {1'b0, b};
    endfunction : lmin
    function automatic logic signed [16:0] lmax(input logic [15:0] a,
                                                input logic [15:0] b);
        lmax = (a > b) ? {1'b0, a} : {1'b0, b};
    endfunction : lmax
    // small-minus-remainder may go negative; the signed min then counts it,
    // matching the 16-bit reference arithmetic
    function automatic logic [2:0] lag_tally(input logic [15:0] l [5]);
        logic signed [16:0] rem;
        logic signed [16:0] sml;
        logic signed [16:0] diff;
        logic [2:0]         n;
        n = vah_pkg::TALLY_INIT;
        for (int j = 1; j <= 4; j++) begin
            rem = lmax(l[j], l[j-1]); // see RULE8
            for (int i = 1; i <= 3; i++) begin
                sml = lmin(l[i], l[i-1]);
                if (rem >= sml) begin
                    rem = rem - sml; // see RULE8
                end
            end
            diff = lmin(l[j], l[j-1]) - rem;
            if (((rem < diff) ? rem : diff) < vah_pkg::MATCH_LIMIT) begin
                n = n + 3'h1; // see RULE9
            end
        end
        lag_tally = n;
    endfunction : lag_tally

    // control register and apb handshake
    logic        enable_q,  enable_d;
    logic        restart_q, restart_d;
    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        wr_fire,   mapped;
    logic [31:0] status_w;
    // detector state
    vah_pkg::vah_state_t state_q, state_d;
    logic [1:0]        burst_q,    burst_d;
    logic signed [3:0] hang_q,     hang_d;
    logic              vad_q,      vad_d;
    logic              raw_q,      raw_d;
    logic              dval_q,     dval_d;
    logic              ptch_q,     ptch_d;
    logic              adapt_q,    adapt_d;
    logic              floor_q,    floor_d;
    logic              limit_q,    limit_d;
    logic              unnorm_q,   unnorm_d;
    logic [2:0]        tally1_q,   tally1_d;
    logic [2:0]        tally2_q,   tally2_d;
    logic [15:0]       lag0_q,     lag0_d;
    logic [15:0]       frames_q,   frames_d;
    logic [19:0]       gap_q,      gap_d;
    logic              overdue_q,  overdue_d;
    logic              frame_fire, lag_fire;
    logic [2:0]        burst_inc,  new_tally;
    logic [15:0]       lag_vec [5];
    localparam vah_pkg::vah_pf_t FLOOR_PF =
        '{exp: vah_pkg::FLOOR_EXP, mant: vah_pkg::FLOOR_MANT}; // see RULE20
    localparam vah_pkg::vah_pf_t LIMIT_PF =
        '{exp: vah_pkg::LIMIT_EXP, mant: vah_pkg::LIMIT_MANT}; // see RULE20
    assign frame_fire = frame_valid && enable_q && !restart_q; // see RULE15
    assign lag_fire   = lags_valid && enable_q && !restart_q
                        && (state_q == vah_pkg::ST_LAGWAIT); // see RULE13

    always_comb begin
        lag_vec[0] = lag0_q; // see RULE11
        for (int k = 1; k <= 4; k++) begin
            lag_vec[k] = lags.lag[k-1]; // see RULE7
        end
    end

    assign new_tally = lag_tally(lag_vec);
    assign burst_inc = {1'b0, burst_q} + 3'h1;

    assign status_w = {7'h00,
                       overdue_q,
                       unnorm_q,
                       limit_q,
                       floor_q,
                       (state_q == vah_pkg::ST_LAGWAIT),
                       1'b0, tally2_q,
                       1'b0, tally1_q,
                       hang_q,
                       2'h0, burst_q,
                       adapt_q, ptch_q, raw_q, vad_q};

    // apb: pready raised for the access phase, zero wait states
    assign mapped  = (paddr == vah_pkg::ADDR_CTRL)
                     || (paddr == vah_pkg::ADDR_STATUS)
                     || (paddr == vah_pkg::ADDR_FRAMES);
    assign wr_fire = psel && penable && pready_q && pwrite
                     && (paddr == vah_pkg::ADDR_CTRL);

    always_comb begin
        pready_d  = psel && !penable;
        pslverr_d = pslverr_q;
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            pslverr_d = !mapped;
            prdata_d  = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    vah_pkg::ADDR_CTRL: begin
                        prdata_d[vah_pkg::CTRL_ENABLE] = enable_q;
                    end
                    vah_pkg::ADDR_STATUS: begin
                        prdata_d = status_w;
                    end
                    vah_pkg::ADDR_FRAMES: begin
                        prdata_d[15:0] = frames_q;
                    end
                    default: begin
                        prdata_d = 32'h0000_0000;
                    end
                endcase
            end
        end else if (!psel) begin
            pslverr_d = 1'b0;
        end
    end

    always_comb begin
        enable_d  = enable_q;
        restart_d = 1'b0;
        if (wr_fire) begin
            enable_d  = pwdata[vah_pkg::CTRL_ENABLE];
            restart_d = pwdata[vah_pkg::CTRL_RESTART];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            enable_q  <= vah_pkg::CTRL_ENABLE_RST;
            restart_q <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
            enable_q  <= enable_d;
            restart_q <= restart_d;
        end
    end

    // frame decision, hold, and periodicity
    always_comb begin
        state_d   = state_q;
        burst_d   = burst_q;
        hang_d    = hang_q;
        vad_d     = vad_q;
        raw_d     = raw_q;
        dval_d    = 1'b0;
        ptch_d    = ptch_q;
        adapt_d   = adapt_q;
        floor_d   = floor_q;
        limit_d   = limit_q;
        unnorm_d  = unnorm_q;
        tally1_d  = tally1_q;
        tally2_d  = tally2_q;
        lag0_d    = lag0_q;
        frames_d  = frames_q;
        if (restart_q) begin
            state_d  = vah_pkg::ST_IDLE; // see RULE16
            burst_d  = vah_pkg::BURST_INIT;
            hang_d   = vah_pkg::HANG_IDLE;
            vad_d    = 1'b0;
            raw_d    = 1'b0;
            ptch_d   = vah_pkg::PTCH_INIT;
            adapt_d  = 1'b0;
            tally1_d = vah_pkg::TALLY_INIT;
            tally2_d = vah_pkg::TALLY_INIT;
            lag0_d   = vah_pkg::LAG0_INIT;
        end else begin
            case (state_q)
                vah_pkg::ST_IDLE: begin
                    if (frame_fire) begin
                        state_d = vah_pkg::ST_LAGWAIT;
                    end
                end
                vah_pkg::ST_LAGWAIT: begin
                    if (lag_fire && !frame_fire) begin
                        state_d = vah_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_d = vah_pkg::ST_IDLE;
                end
            endcase
            if (frame_fire) begin
                dval_d   = 1'b1;
                frames_d = frames_q + 16'h0001;
                raw_d    = pf_gt(filt_energy, thresh); // see RULE22
                burst_d  = raw_d ? burst_inc[1:0] : 2'h0; // see RULE2
                if (raw_d && (burst_inc >= {1'b0, vah_pkg::BURST_LIMIT})) begin
                    hang_d  = vah_pkg::HANG_LOAD; // see RULE1
                    burst_d = vah_pkg::BURST_LIMIT; // see RULE1
                end
                vad_d = raw_d || (hang_d >= 4'sh0); // see RULE3
                if (hang_d >= 4'sh0) begin
                    hang_d = hang_d - 4'sh1; // see RULE3
                end
                // ptch_q here still belongs to the previous frame
                adapt_d  = !ptch_q; // see RULE6, RULE14
                floor_d  = pf_gt(FLOOR_PF, input_frame_energy);
                limit_d  = pf_gt(LIMIT_PF, thresh);
                unnorm_d = (filt_energy.mant < vah_pkg::MANT_NORM_MIN)
                    || (thresh.mant < vah_pkg::MANT_NORM_MIN)
                    || (input_frame_energy.mant
                        < vah_pkg::MANT_NORM_MIN); // see RULE18
            end
            if (lag_fire && !frame_fire) begin
                tally2_d = tally1_q; // see RULE10
                tally1_d = new_tally; // see RULE10
                ptch_d   = ({1'b0, tally1_d} + {1'b0, tally2_d})
                           >= vah_pkg::PERIODIC_MIN; // see RULE5
                adapt_d  = adapt_q && !ptch_d; // see RULE6
                lag0_d   = lags.lag[3]; // see RULE11
            end
        end
    end

    // watchdog: a frame strobe should come every frame period
    always_comb begin
        gap_d     = gap_q;
        overdue_d = overdue_q;
        if (frame_fire || restart_q) begin
            gap_d     = 20'h0_0000;
            overdue_d = 1'b0;
        end else if (gap_q >= FRAME_CYCLES[19:0]) begin
            overdue_d = 1'b1;
        end else begin
            gap_d = gap_q + 20'h0_0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= vah_pkg::ST_IDLE; // see RULE16
            burst_q   <= vah_pkg::BURST_INIT; // see RULE4
            hang_q    <= vah_pkg::HANG_IDLE; // see RULE4
            vad_q     <= 1'b0;
            raw_q     <= 1'b0;
            dval_q    <= 1'b0;
            ptch_q    <= vah_pkg::PTCH_INIT; // see RULE12
            adapt_q   <= 1'b0;
            floor_q   <= 1'b0;
            limit_q   <= 1'b0;
            unnorm_q  <= 1'b0;
            tally1_q  <= vah_pkg::TALLY_INIT; // see RULE12
            tally2_q  <= vah_pkg::TALLY_INIT; // see RULE12
            lag0_q    <= vah_pkg::LAG0_INIT; // see RULE11
            frames_q  <= 16'h0000;
            gap_q     <= 20'h0_0000;
            overdue_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            burst_q   <= burst_d;
            hang_q    <= hang_d;
            vad_q     <= vad_d;
            raw_q     <= raw_d;
            dval_q    <= dval_d;
            ptch_q    <= ptch_d;
            adapt_q   <= adapt_d;
            floor_q   <= floor_d;
            limit_q   <= limit_d;
            unnorm_q  <= unnorm_d;
            tally1_q  <= tally1_d;
            tally2_q  <= tally2_d;
            lag0_q    <= lag0_d;
            frames_q  <= frames_d;
            gap_q     <= gap_d;
            overdue_q <= overdue_d;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign vad_flag           = vad_q;
    assign raw_flag           = raw_q;
    assign decision_valid     = dval_q;
    assign periodic           = ptch_q;
    assign adapt_allow        = adapt_q;
    assign energy_below_floor = floor_q;
    assign thresh_below_limit = limit_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_hold_load: assert property ( // see RULE1
        frame_fire && !restart_q && raw_d && burst_q >= 2'h2
        |=> hang_q == 4'sh4 && burst_q == 2'h3 && vad_q)
        else $error("hold counter not loaded after run of three");
    chk_run_clear: assert property ( // see RULE2
        frame_fire && !raw_d |=> burst_q == 2'h0)
        else $error("run counter not cleared on inactive frame");
    chk_held_flag: assert property ( // see RULE3
        frame_fire && hang_q >= 4'sh0 && !raw_d
        |=> vad_q && hang_q == $past(hang_q) - 4'sh1)
        else $error("held flag or hold countdown wrong");
    chk_reset_init: assert property ( // see RULE4, RULE12
        $rose(resetn) |-> hang_q == -4'sh1 && burst_q == 2'h0
        && ptch_q && tally1_q == 3'h0 && lag0_q == 16'h0015)
        else $error("state not at initial values after reset");
    chk_ptch_cause: assert property ( // see RULE5, RULE13
        $changed(ptch_q) |-> $past(lag_fire) || $past(restart_q))
        else $error("periodic flag moved without lags strobe");
    chk_adapt_block: assert property ( // see RULE6
        ptch_q |-> ##[0:1] !adapt_q)
        else $error("adaptation allowed while periodic");
    chk_tally_sum: assert property ( // see RULE10
        lag_fire && !frame_fire |=> tally2_q == $past(tally1_q)
        && ptch_q == (({1'b0, tally1_q} + {1'b0, tally2_q}) >= 4'h7))
        else $error("tally shift or periodic sum wrong");
    chk_lag_carry: assert property ( // see RULE11
        lag_fire && !frame_fire |=> lag0_q == $past(lags.lag[3]))
        else $error("last lag not carried to next frame");
    chk_raw_compare: assert property ( // see RULE22
        frame_fire |=> raw_q == $past(pf_gt(filt_energy, thresh))
        && decision_valid)
        else $error("raw decision does not follow energy compare");
    chk_prev_ptch: assert property ( // see RULE14
        frame_fire && ptch_q |=> !adapt_q)
        else $error("decision used periodic flag of wrong frame");

    cov_hold_tail: cover property (
        frame_fire && !raw_d && hang_q == 4'sh0);
    cov_ptch_fall: cover property (lag_fire ##1 !ptch_q);
    cov_apb_write: cover property (wr_fire);

endmodule : vah_top
`default_nettype wire

// *** vah_pkg.sv ***
`default_nettype none
package vah_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned FRAME_PERIOD_MS = 20;
    localparam int unsigned FRAME_CYCLES    =
        FRAME_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    // hold (hangover) constants
    localparam logic [1:0]        BURST_LIMIT = 2'h3;
    localparam logic [1:0]        BURST_INIT  = 2'h0;
    localparam logic signed [3:0] HANG_LOAD   = 4'sh5;
    localparam logic signed [3:0] HANG_IDLE   = -4'sh1;

    // periodicity constants
    localparam logic signed [16:0] MATCH_LIMIT  = 17'sh0_0002;
    localparam logic [3:0]         PERIODIC_MIN = 4'h7;
    localparam logic [2:0]         TALLY_INIT   = 3'h0;
    localparam logic [15:0]        LAG0_INIT    = 16'h0015;
    localparam logic               PTCH_INIT    = 1'b1;

    // pseudo-float format
    localparam logic [15:0] MANT_NORM_MIN = 16'h4000;
    localparam logic [15:0] FLOOR_EXP     = 16'h0012;
    localparam logic [15:0] FLOOR_MANT    = 16'h668A;
    localparam logic [15:0] MARGIN_EXP    = 16'h001B;
    localparam logic [15:0] MARGIN_MANT   = 16'h6ACF;
    localparam logic [15:0] LIMIT_EXP     = 16'h0014;
    localparam logic [15:0] LIMIT_MANT    = 16'h445C;

    // register map
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_FRAMES = 12'h008;
    localparam int unsigned CTRL_ENABLE  = 0;
    localparam int unsigned CTRL_RESTART = 1;
    localparam logic        CTRL_ENABLE_RST = 1'b1;
    localparam int unsigned ST_VAD     = 0;
    localparam int unsigned ST_RAW     = 1;
    localparam int unsigned ST_PTCH    = 2;
    localparam int unsigned ST_ADAPT   = 3;
    localparam int unsigned ST_BURST   = 4;
    localparam int unsigned ST_HANG    = 8;
    localparam int unsigned ST_TALLY1  = 12;
    localparam int unsigned ST_TALLY2  = 16;
    localparam int unsigned ST_WAIT    = 20;
    localparam int unsigned ST_FLOOR   = 21;
    localparam int unsigned ST_LIMIT   = 22;
    localparam int unsigned ST_UNNORM  = 23;
    localparam int unsigned ST_OVERDUE = 24;

    typedef struct packed {
        logic signed [15:0] exp;
        logic [15:0]        mant;
    } vah_pf_t;

    typedef struct packed {
        logic [3:0][15:0] lag;
    } vah_lags_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_LAGWAIT = 2'b10
    } vah_state_t;
endpackage : vah_pkg
`default_nettype wire

// *** vah_enc_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vah_enc_model (
    input  wire logic          clk,
    output logic               frame_valid,
    output vah_pkg::vah_pf_t   filt_energy,
    output vah_pkg::vah_pf_t   thresh,
    output vah_pkg::vah_pf_t   input_frame_energy,
    output logic               lags_valid,
    output vah_pkg::vah_lags_t lags
);
    initial begin
        frame_valid = 1'b0;
        lags_valid = 1'b0;
        filt_energy = '0;
        thresh = '0;
        input_frame_energy = '0;
        lags = '0;
    end
    // data is scrambled once the strobe drops, nothing stale survives
    task automatic send_frame(input vah_pkg::vah_pf_t fe, th, ie);
        @(posedge clk);
        frame_valid <= 1'b1;
        filt_energy <= fe;
        thresh <= th;
        input_frame_energy <= ie;
        @(posedge clk);
        frame_valid <= 1'b0;
        filt_energy <= ~fe;
        thresh <= ~th;
        input_frame_energy <= ~ie;
    endtask : send_frame
    task automatic send_lags(input vah_pkg::vah_lags_t l);
        @(posedge clk);
        lags_valid <= 1'b1;
        lags <= l;
        @(posedge clk);
        lags_valid <= 1'b0;
        lags <= ~l;
    endtask : send_lags
endmodule : vah_enc_model
`default_nettype wire

// *** vah_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", nm, e, g); \
    n_mismatch++; end end
module voice_activity_hold_periodicity_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, frame_valid, lags_valid;
    logic vad_flag, raw_flag, decision_valid, periodic, adapt_allow;
    logic energy_below_floor, thresh_below_limit;
    vah_pkg::vah_pf_t filt_energy, thresh, input_frame_energy;
    vah_pkg::vah_lags_t lags;
    int n_mismatch = 0;
    int checked = 0;
    localparam vah_pkg::vah_pf_t TH = {16'sh0009, 16'h6000};
    localparam vah_pkg::vah_pf_t FL = {16'sh0012, 16'h668A};
    always #20 clk = ~clk;
    vah_top #(.FRAME_CYCLES(1000)) DUT (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_valid(frame_valid),
        .filt_energy(filt_energy), .thresh(thresh),
        .input_frame_energy(input_frame_energy), .lags_valid(lags_valid),
        .lags(lags), .vad_flag(vad_flag), .raw_flag(raw_flag),
        .decision_valid(decision_valid), .periodic(periodic),
        .adapt_allow(adapt_allow), .energy_below_floor(energy_below_floor),
        .thresh_below_limit(thresh_below_limit));
    vah_enc_model ENC (.clk(clk), .frame_valid(frame_valid),
        .filt_energy(filt_energy), .thresh(thresh),
        .input_frame_energy(input_frame_energy), .lags_valid(lags_valid),
        .lags(lags));
    task automatic report_and_stop;
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : apb
    task automatic frame(input vah_pkg::vah_pf_t fe, th, ie);
        ENC.send_frame(fe, th, ie);
        #1;
        `CHK("decision_valid", 1'b1, decision_valid)
    endtask : frame
    task automatic t_reset;
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("periodic_rst", 1'b1, rd[2])
        `CHK("hold_rst", 4'hF, rd[11:8])
        `CHK("run_rst", 2'h0, rd[5:4])
        `CHK("tally_rst", 6'h00, {rd[18:16], rd[14:12]})
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_data", 32'h0000_0000, rd)
        apb(1'b1, 12'h000, 32'h0000_0000);
        ENC.send_frame(TH, TH, FL);
        #1;
        `CHK("refused_frame", 1'b0, decision_valid)
        apb(1'b1, 12'h000, 32'h0000_0001);
    endtask : t_reset
    task automatic t_ptch;
        for (int f = 0; f < 3; f++) begin
            frame(TH, TH, FL);
            `CHK("adapt_allow", f != 0, adapt_allow)
            ENC.send_lags({4{16'h0028}});
            #1;
            `CHK("periodic", f == 2, periodic)
            if (f == 1) begin
                apb(1'b0, 12'h004, 32'h0000_0000);
                `CHK("tallies", 6'h04, {rd[18:16], rd[14:12]})
            end
        end
        `CHK("adapt_forced", 1'b0, adapt_allow)
        frame(TH, TH, FL);
        `CHK("adapt_prev", 1'b0, adapt_allow)
    endtask : t_ptch
    task automatic t_hang;
        logic [11:0] rw;
        logic [11:0] vd;
        vah_pkg::vah_pf_t fe;
        rw = 12'b1101_1100_0000;
        vd = 12'b1101_1111_1110;
        // only a run of three opens a hold; run of two must not
        for (int i = 11; i >= 0; i--) begin
            if (rw[i]) begin
                fe = i[0] ? {16'sh000A, 16'h4000} : {16'sh0009, 16'h6001};
            end else begin
                fe = i[0] ? {16'sh0008, 16'h7FFF} : TH;
            end
            frame(fe, TH, FL);
            `CHK("raw_flag", rw[i], raw_flag)
            `CHK("vad_flag", vd[i], vad_flag)
        end
    endtask : t_hang
    task automatic t_floor;
        for (int k = 0; k < 2; k++) begin
            frame(TH, {16'sh0014, k ? 16'h445C : 16'h445B},
                  {16'sh0012, k ? 16'h668A : 16'h6689});
            `CHK("below_floor", k == 0, energy_below_floor)
            `CHK("below_limit", k == 0, thresh_below_limit)
        end
    endtask : t_floor
    // restart must clear tallies and lag zero, not the frame count
    task automatic t_restart;
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHK("frames", 32'h0000_0012, rd)
        apb(1'b1, 12'h000, 32'h0000_0003);
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("tally_restart", 6'h00, {rd[18:16], rd[14:12]})
        `CHK("periodic_restart", 1'b1, rd[2])
        frame(TH, TH, {16'sh0012, 16'h3FFF});
        ENC.send_lags({4{16'h0015}});
        #1;
        `CHK("periodic_lag0", 1'b0, periodic)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("tally_lag0", 3'h4, rd[14:12])
        `CHK("unnormalised", 1'b1, rd[23])
        `CHK("overdue_early", 1'b0, rd[24])
        repeat (1000) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("overdue_late", 1'b1, rd[24])
    endtask : t_restart
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_ptch();
        t_hang();
        t_floor();
        t_restart();
        report_and_stop();
    end
endmodule : voice_activity_hold_periodicity_tb_top
`default_nettype wire
